// ---- shared/hbu_defs.svh ----
// offsets, field positions, reset values and command codes of the host bus unit
`ifndef HBU_DEFS_SVH
`define HBU_DEFS_SVH
// ==========================================================
// register byte offsets
`define HBU_OFS_HEAD 12'h000
`define HBU_OFS_CTRL 12'h004
`define HBU_OFS_STAT 12'h008
`define HBU_OFS_MASK 12'h00C
`define HBU_OFS_TXST 12'h010
// ==========================================================
// burst control fields and reset values
`define HBU_CTRL_MAXB_LSB 0
`define HBU_CTRL_LINE_LSB 8
`define HBU_CTRL_MRM_EN 16
`define HBU_CTRL_MWI_EN 17
`define HBU_CTRL_RST 32'h0003_0810
`define HBU_HEAD_RST 32'h0000_0000
// ==========================================================
// interrupt status bits
`define HBU_EV_TXDONE 0
`define HBU_EV_RX 1
`define HBU_EV_LISTEND 2
`define HBU_EV_W 3
// ==========================================================
// descriptor layout
`define HBU_FCW_NOTIFY 31
`define HBU_FCW_NFRAG_LSB 0
`define HBU_DESC_FRAG0 32'h0000_0008
`define HBU_FETCH_LEN 8'h02
// ==========================================================
// pci memory command codes
`define HBU_CMD_MR 4'h6
`define HBU_CMD_MRL 4'hE
`define HBU_CMD_MRM 4'hC
`define HBU_CMD_MW 4'h7
`define HBU_CMD_MWI 4'hF
`endif

// ---- shared/hbu_pkg.sv ----
// types of the host bus unit
package hbu_pkg;
  // ==========================================================
  // transmit mover and master port states
  typedef enum logic [2:0] {
    T_IDLE, T_HDR, T_FRAG, T_DATA, T_DONE
  } hbu_tx_st_t;
  typedef enum logic [1:0] {P_IDLE, P_REQ, P_DATA} hbu_port_st_t;
  // ==========================================================
  // whole state of the top module
  typedef struct packed {
    hbu_tx_st_t tst;
    hbu_port_st_t pst;
    logic own_rx;
    logic wcnt;
    logic [31:0] head;
    logic [31:0] link;
    logic [31:0] fcw;
    logic [3:0] fidx;
    logic [31:0] faddr;
    logic [15:0] fleft;
    logic [31:0] ctrl;
    logic [2:0] status;
    logic [2:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic intr;
    logic oe;
    logic int_oe;
    logic req;
    logic [3:0] cmd;
    logic [31:0] addr;
    logic [7:0] len;
    logic rx_done;
  } hbu_top_t;
  // ==========================================================
  // whole state of the arbiter
  typedef struct packed {
    logic gnt_tx;
    logic gnt_rx;
    logic last_rx;
    logic [3:0] rx_cmd;
  } hbu_arb_t;
endpackage : hbu_pkg

// ---- src/hbu_arb.sv ----
// master port arbiter and receive command picker
`timescale 1ns/1ps
`include "hbu_defs.svh"
module hbu_arb (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic tx_req_i,
  input wire logic rx_req_i,
  input wire logic busy_i,
  input wire logic load_i,
  input wire logic rx_desc_i,
  input wire logic [15:0] rx_bytes_left_i,
  input wire logic [7:0] rxq_level_i,
  input wire logic [7:0] line_i,
  input wire logic mwi_en_i,
  output logic gnt_tx_o,
  output logic gnt_rx_o,
  output logic [3:0] rx_cmd_o
);
  hbu_pkg::hbu_arb_t s;
  hbu_pkg::hbu_arb_t n;
  logic [15:0] line_bytes;

  assign line_bytes = {6'h00, line_i, 2'b00};

  // ==========================================================
  // grant and command choice
  always_comb begin
    n = s;
    // grants only move while the port is free, so a burst keeps its owner
    if (!busy_i && !load_i) begin
      n.gnt_tx = tx_req_i && (!rx_req_i || s.last_rx); // RULE_02
      n.gnt_rx = rx_req_i && !n.gnt_tx; // RULE_02
      if (n.gnt_rx) begin
        n.last_rx = 1'b1;
      end else if (n.gnt_tx) begin
        n.last_rx = 1'b0;
      end
    end
    // descriptor writes are always plain writes
    if (rx_desc_i) begin
      n.rx_cmd = `HBU_CMD_MW; // RULE_07
    end else if (mwi_en_i && !tx_req_i && line_i != 8'h00 &&
                 rx_bytes_left_i >= line_bytes && rxq_level_i >= line_i) begin
      n.rx_cmd = `HBU_CMD_MWI; // RULE_08
    end else begin
      n.rx_cmd = `HBU_CMD_MW; // RULE_08
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign gnt_tx_o = s.gnt_tx;
  assign gnt_rx_o = s.gnt_rx;
  assign rx_cmd_o = s.rx_cmd;
endmodule : hbu_arb

// ---- src/hbu_top.sv ----
// host bus unit: register slave, master port, transmit descriptor mover
// Overview of operation
// [RULE_01] acts as bus master for movers and as register target for host
// [RULE_02] arbiter grants master port to transmit or receive mover in turn
// [RULE_03] mover events set status bits that drive the interrupt request
// [RULE_04] memory command is chosen anew for each burst issued
// [RULE_05] descriptor fetches always use plain memory read
// [RULE_06] frame reads pick read, line or multiple by size, space, rx request
// [RULE_07] descriptor writes always use plain memory write
// [RULE_08] receive data writes pick write or invalidate from size, level, tx
// [RULE_09] burst control register trades bus efficiency against underruns
// [RULE_10] pci reset low turns off every pci output enable
// [RULE_11] transmit and receive movers run as independent processes
// [RULE_12] descriptor holds link, control word and 1 to 15 fragments
// [RULE_13] all fragments of one descriptor form a single frame
// [RULE_14] mover follows the link pointer to the next descriptor
// [RULE_15] all logic runs on the single core clock
// [RULE_16] list head resets to zero; a nonzero write starts transmit
// [RULE_17] frame moved with notify bit set raises transmit done event
// [RULE_18] zero link pointer ends the list and stops fetching
`timescale 1ns/1ps
`include "hbu_defs.svh"
module hbu_top #(
  parameter int MAX_FRAGS = 15
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic pci_rst_b_i,
  output logic mst_oe_o,
  output logic mst_req_o,
  output logic [3:0] mst_cmd_o,
  output logic [31:0] mst_addr_o,
  output logic [7:0] mst_len_o,
  input wire logic mst_ack_i,
  input wire logic mst_rvalid_i,
  input wire logic [31:0] mst_rdata_i,
  input wire logic mst_last_i,
  input wire logic [7:0] txq_free_i,
  input wire logic rx_req_i,
  input wire logic rx_desc_i,
  input wire logic [31:0] rx_addr_i,
  input wire logic [7:0] rx_len_i,
  input wire logic [15:0] rx_bytes_left_i,
  input wire logic [7:0] rxq_level_i,
  input wire logic rx_event_i,
  output logic rx_done_o,
  output logic int_o,
  output logic int_oe_o
);
  // ==========================================================
  // elaboration check
  if (MAX_FRAGS < 1 || MAX_FRAGS > 15) begin : g_bad_frags
    $error("MAX_FRAGS must lie between 1 and 15");
  end

  localparam logic [3:0] MAXF = 4'(MAX_FRAGS);

  hbu_pkg::hbu_top_t s;
  hbu_pkg::hbu_top_t n;

  logic [7:0] maxb;
  logic [7:0] line;
  logic [3:0] nfrag;
  logic [13:0] wleft;
  logic [7:0] wl8;
  logic [7:0] blen;
  logic [3:0] tx_cmd;
  logic [31:0] tx_addr;
  logic [7:0] tx_len;
  logic tx_want;
  logic tx_fly;
  logic done;
  logic gnt_tx;
  logic gnt_rx;
  logic [3:0] rx_cmd;
  logic load;
  logic rx_ok;
  logic setup;
  logic wr;
  logic [2:0] set;
  logic [2:0] clr;
  logic [15:0] bbytes;

  // ==========================================================
  // burst settings and fragment bookkeeping
  assign maxb = s.ctrl[`HBU_CTRL_MAXB_LSB +: 8]; // RULE_09
  assign line = s.ctrl[`HBU_CTRL_LINE_LSB +: 8]; // RULE_09
  // a count above the allowed number is clamped rather than overrun
  assign nfrag = (s.fcw[`HBU_FCW_NFRAG_LSB +: 4] > MAXF) ?
                 MAXF : s.fcw[`HBU_FCW_NFRAG_LSB +: 4]; // RULE_12
  assign wleft = s.fleft[15:2] + {13'h0000, |s.fleft[1:0]};
  assign wl8 = (wleft > 14'h00FF) ? 8'hFF : wleft[7:0];

  // burst length is the least of data left, limit and queue space
  always_comb begin
    blen = wl8;
    if (maxb != 8'h00 && maxb < blen) begin
      blen = maxb;
    end
    if (txq_free_i < blen) begin
      blen = txq_free_i;
    end
  end

  assign bbytes = ({6'h00, blen, 2'b00} > s.fleft) ?
                  s.fleft : {6'h00, blen, 2'b00};

  // ==========================================================
  // transmit request and command choice
  always_comb begin
    tx_cmd = `HBU_CMD_MR; // RULE_05
    tx_addr = s.head;
    tx_len = `HBU_FETCH_LEN;
    tx_want = 1'b0;
    case (s.tst)
      hbu_pkg::T_HDR: begin
        tx_want = 1'b1;
      end
      hbu_pkg::T_FRAG: begin
        tx_want = s.fidx < nfrag;
        tx_addr = s.head + `HBU_DESC_FRAG0 + {25'h000_0000, s.fidx, 3'b000};
      end
      hbu_pkg::T_DATA: begin
        tx_want = s.fleft != 16'h0000 && blen != 8'h00;
        tx_addr = s.faddr;
        tx_len = blen;
        // long bursts only while the receive side leaves the bus alone
        if (s.ctrl[`HBU_CTRL_MRM_EN] && !rx_req_i && line != 8'h00 &&
            {1'b0, blen} >= {line, 1'b0}) begin
          tx_cmd = `HBU_CMD_MRM; // RULE_06
        end else if (line != 8'h00 && blen >= line) begin
          tx_cmd = `HBU_CMD_MRL; // RULE_06
        end else begin
          tx_cmd = `HBU_CMD_MR; // RULE_06
        end
      end
      default: begin
        tx_want = 1'b0;
      end
    endcase
  end

  assign tx_fly = s.pst != hbu_pkg::P_IDLE && !s.own_rx;
  assign done = s.pst == hbu_pkg::P_DATA && mst_rvalid_i && mst_last_i;
  // the done flag masks a request the receive mover has not yet dropped
  assign rx_ok = rx_req_i && !s.rx_done;
  assign load = s.pst == hbu_pkg::P_IDLE &&
                ((gnt_tx && tx_want) || (gnt_rx && rx_ok));

  // ==========================================================
  // arbiter and receive command picker
  hbu_arb u_arb (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .tx_req_i(tx_want && !tx_fly),
    .rx_req_i(rx_ok),
    .busy_i(s.pst != hbu_pkg::P_IDLE),
    .load_i(load),
    .rx_desc_i(rx_desc_i),
    .rx_bytes_left_i(rx_bytes_left_i),
    .rxq_level_i(rxq_level_i),
    .line_i(line),
    .mwi_en_i(s.ctrl[`HBU_CTRL_MWI_EN]),
    .gnt_tx_o(gnt_tx),
    .gnt_rx_o(gnt_rx),
    .rx_cmd_o(rx_cmd)
  );

  // ==========================================================
  // register access decode
  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && s.pready && pwrite_i;
  assign clr = (wr && paddr_i == `HBU_OFS_STAT) ?
               pwdata_i[`HBU_EV_W-1:0] : 3'b000;

  // ==========================================================
  // next state
  always_comb begin
    n = s;
    set = 3'b000;
    n.rx_done = 1'b0;
    // register read data is prepared in the setup cycle
    n.pready = setup;
    n.pslverr = 1'b0;
    if (setup) begin
      case (paddr_i)
        `HBU_OFS_HEAD: n.prdata = s.head;
        `HBU_OFS_CTRL: n.prdata = s.ctrl;
        `HBU_OFS_STAT: n.prdata = {29'h0000_0000, s.status};
        `HBU_OFS_MASK: n.prdata = {29'h0000_0000, s.mask};
        `HBU_OFS_TXST: n.prdata = {9'h000, s.tst, s.fidx, s.fleft};
        default: begin
          n.prdata = 32'h0000_0000;
          n.pslverr = 1'b1;
        end
      endcase
    end
    // the head is only taken while the mover is idle
    if (wr && paddr_i == `HBU_OFS_HEAD && s.tst == hbu_pkg::T_IDLE) begin
      n.head = pwdata_i; // RULE_16
    end
    if (wr && paddr_i == `HBU_OFS_CTRL) begin
      n.ctrl = pwdata_i; // RULE_09
    end
    if (wr && paddr_i == `HBU_OFS_MASK) begin
      n.mask = pwdata_i[`HBU_EV_W-1:0];
    end

    // master port sequencing, one burst at a time
    case (s.pst)
      hbu_pkg::P_IDLE: begin
        if (gnt_tx && tx_want) begin
          n.req = 1'b1; // RULE_01
          n.cmd = tx_cmd; // RULE_04
          n.addr = tx_addr;
          n.len = tx_len;
          n.own_rx = 1'b0;
          n.wcnt = 1'b0;
          n.pst = hbu_pkg::P_REQ;
          if (s.tst == hbu_pkg::T_DATA) begin
            n.faddr = s.faddr + {22'h00_0000, blen, 2'b00};
            n.fleft = s.fleft - bbytes;
          end
        end else if (gnt_rx && rx_ok) begin
          n.req = 1'b1; // RULE_11
          n.cmd = rx_cmd; // RULE_04
          n.addr = rx_addr_i;
          n.len = rx_len_i;
          n.own_rx = 1'b1;
          n.pst = hbu_pkg::P_REQ;
        end
      end
      hbu_pkg::P_REQ: begin
        if (mst_ack_i) begin
          n.req = 1'b0;
          n.pst = hbu_pkg::P_DATA;
        end
      end
      hbu_pkg::P_DATA: begin
        if (mst_rvalid_i && !s.own_rx) begin
          n.wcnt = ~s.wcnt;
          if (s.tst == hbu_pkg::T_HDR) begin
            if (!s.wcnt) begin
              n.link = mst_rdata_i; // RULE_14
            end else begin
              n.fcw = mst_rdata_i; // RULE_12
            end
          end else if (s.tst == hbu_pkg::T_FRAG) begin
            if (!s.wcnt) begin
              n.faddr = mst_rdata_i;
            end else begin
              n.fleft = mst_rdata_i[15:0];
            end
          end
        end
        if (done) begin
          n.pst = hbu_pkg::P_IDLE;
          n.rx_done = s.own_rx;
        end
      end
      default: begin
        n.pst = hbu_pkg::P_IDLE;
      end
    endcase

    // transmit descriptor walk
    case (s.tst)
      hbu_pkg::T_IDLE: begin
        if (s.head != 32'h0000_0000) begin
          n.tst = hbu_pkg::T_HDR; // RULE_16
        end
      end
      hbu_pkg::T_HDR: begin
        if (done && !s.own_rx) begin
          n.tst = hbu_pkg::T_FRAG;
          n.fidx = 4'h0;
        end
      end
      hbu_pkg::T_FRAG: begin
        if (!tx_fly && s.fidx >= nfrag) begin
          n.tst = hbu_pkg::T_DONE; // RULE_13
        end else if (done && !s.own_rx) begin
          n.tst = hbu_pkg::T_DATA;
        end
      end
      hbu_pkg::T_DATA: begin
        // the last burst must land before the next fragment is fetched
        if (!tx_fly && s.fleft == 16'h0000) begin
          n.fidx = s.fidx + 4'h1;
          n.tst = hbu_pkg::T_FRAG; // RULE_13
        end
      end
      hbu_pkg::T_DONE: begin
        set[`HBU_EV_TXDONE] = s.fcw[`HBU_FCW_NOTIFY]; // RULE_17
        n.head = s.link; // RULE_14
        if (s.link == 32'h0000_0000) begin
          set[`HBU_EV_LISTEND] = 1'b1; // RULE_18
        end
        n.tst = hbu_pkg::T_IDLE;
      end
      default: begin
        n.tst = hbu_pkg::T_IDLE;
      end
    endcase

    // sticky events: a new event wins over a clear in the same cycle
    set[`HBU_EV_RX] = rx_event_i; // RULE_03
    n.status = (s.status & ~clr) | set; // RULE_03
    n.intr = |(n.status & n.mask); // RULE_03

    // pci reset only parks the pins; the movers keep their state
    n.oe = pci_rst_b_i; // RULE_10
    n.int_oe = pci_rst_b_i && n.intr; // RULE_10
    if (!pci_rst_b_i) begin
      n.req = 1'b0; // RULE_10
    end
  end

  // ==========================================================
  // state register on the core clock
  always_ff @(posedge clock_i or negedge rst_b_i) begin // RULE_15
    if (!rst_b_i) begin
      s <= '0;
      s.tst <= hbu_pkg::T_IDLE;
      s.pst <= hbu_pkg::P_IDLE;
      s.head <= `HBU_HEAD_RST; // RULE_16
      s.ctrl <= `HBU_CTRL_RST;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // outputs, each straight from the state register
  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign mst_oe_o = s.oe;
  assign mst_req_o = s.req;
  assign mst_cmd_o = s.cmd;
  assign mst_addr_o = s.addr;
  assign mst_len_o = s.len;
  assign rx_done_o = s.rx_done;
  assign int_o = s.intr;
  assign int_oe_o = s.int_oe;
endmodule : hbu_top

// ---- test/hbu_top_sva.sv ----
// port assertions of the host bus unit, bound to hbu_top
`timescale 1ns/1ps
`include "hbu_defs.svh"
module hbu_top_sva #(
  parameter int MAX_FRAGS = 15
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic pci_rst_b_i,
  input wire logic mst_oe_o,
  input wire logic mst_req_o,
  input wire logic [3:0] mst_cmd_o,
  input wire logic [31:0] mst_addr_o,
  input wire logic [7:0] mst_len_o,
  input wire logic mst_ack_i,
  input wire logic mst_last_i,
  input wire logic rx_req_i,
  input wire logic rx_desc_i,
  input wire logic rx_done_o,
  input wire logic int_oe_o
);
  // ==========================================================
  // one clock domain, so defaults are declared once
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_answer;
    pready_o ##1 !pready_o;
  endsequence
  // ==========================================================
  // register slave and master port relations
  property p_apb_answer;
    s_setup |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("ready not a single cycle after setup");
  property p_slverr;
    pslverr_o |-> pready_o;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("error response without ready");
  property p_tristate;
    !pci_rst_b_i |=> !mst_oe_o && !int_oe_o && !mst_req_o;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("bus outputs enabled during bus reset");
  property p_req_oe;
    mst_req_o |-> mst_oe_o;
  endproperty
  a_req_oe: assert property (p_req_oe)
    else $error("request with outputs disabled");
  property p_req_hold;
    mst_req_o && !mst_ack_i && pci_rst_b_i |=> mst_req_o &&
      $stable(mst_cmd_o) && $stable(mst_addr_o) && $stable(mst_len_o);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before ack");
  property p_cmd_legal;
    mst_req_o |-> mst_cmd_o inside {`HBU_CMD_MR, `HBU_CMD_MRL,
      `HBU_CMD_MRM, `HBU_CMD_MW, `HBU_CMD_MWI};
  endproperty
  a_cmd_legal: assert property (p_cmd_legal)
    else $error("illegal memory command");
  property p_desc_write;
    mst_req_o && rx_req_i && rx_desc_i && mst_cmd_o == `HBU_CMD_MWI
      |-> 1'b0;
  endproperty
  a_desc_write: assert property (p_desc_write)
    else $error("descriptor write with invalidate");
  property p_mwi_data;
    mst_req_o && mst_cmd_o == `HBU_CMD_MWI |-> rx_req_i && !rx_desc_i;
  endproperty
  a_mwi_data: assert property (p_mwi_data)
    else $error("invalidate without receive data");
  property p_ack_drop;
    mst_req_o && mst_ack_i |=> !mst_req_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("request held after ack");
  property p_done_pulse;
    rx_done_o |-> rx_req_i ##1 !rx_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("receive done not a single pulse");
  property p_last_gap;
    mst_last_i |=> !mst_req_o;
  endproperty
  a_last_gap: assert property (p_last_gap)
    else $error("request right after last word");
endmodule : hbu_top_sva
bind hbu_top hbu_top_sva #(.MAX_FRAGS(MAX_FRAGS)) u_sva (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .pci_rst_b_i(pci_rst_b_i), .mst_oe_o(mst_oe_o), .mst_req_o(mst_req_o),
  .mst_cmd_o(mst_cmd_o), .mst_addr_o(mst_addr_o), .mst_len_o(mst_len_o),
  .mst_ack_i(mst_ack_i), .mst_last_i(mst_last_i), .rx_req_i(rx_req_i),
  .rx_desc_i(rx_desc_i), .rx_done_o(rx_done_o), .int_oe_o(int_oe_o));

// ---- test/hbu_mem.sv ----
// host memory model answering the master port
`timescale 1ns/1ps
`include "hbu_defs.svh"
module hbu_mem (
  input wire logic clock_i,
  input wire logic pci_rst_b_i,
  input wire logic mst_req_i,
  input wire logic [3:0] mst_cmd_i,
  input wire logic [31:0] mst_addr_i,
  input wire logic [7:0] mst_len_i,
  output logic mst_ack_o,
  output logic mst_rvalid_o,
  output logic [31:0] mst_rdata_o,
  output logic mst_last_o
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] a;
  logic [3:0] last_wcmd = 4'h0, rd_cmd;
  int n_desc = 0, n_bad = 0, n_words = 0, n;
  initial {mst_ack_o, mst_rvalid_o, mst_last_o, mst_rdata_o} = '0;
  // one burst at a time; bus reset is only checked when a request is first seen
  always begin
    @(posedge clock_i);
    if (mst_req_i === 1'b1 && pci_rst_b_i === 1'b1) begin
      repeat ($urandom_range(0, 2)) @(posedge clock_i);
      a = mst_addr_i;
      n = mst_len_i;
      // low region holds descriptors: plain read of two words only
      if (a < 32'h0000_1000) begin
        n_desc++;
        if (mst_cmd_i != `HBU_CMD_MR || n != 2) n_bad++;
      end else if (mst_cmd_i inside {`HBU_CMD_MW, `HBU_CMD_MWI}) begin
        last_wcmd = mst_cmd_i;
      end else begin
        n_words += n;
        // the bench sets an 8-word line and bursts stay below two lines
        rd_cmd = (n < 8) ? `HBU_CMD_MR : `HBU_CMD_MRL;
        if (mst_cmd_i != rd_cmd) n_bad++;
      end
      mst_ack_o <= 1'b1;
      @(posedge clock_i);
      mst_ack_o <= 1'b0;
      // random stalls; a stalled data line toggles, never repeats
      for (int i = 0; i < n; i++) begin
        if ($urandom_range(0, 3) == 0) begin
          mst_rvalid_o <= 1'b0;
          mst_rdata_o <= ~mst_rdata_o;
          @(posedge clock_i);
        end
        mst_rvalid_o <= 1'b1;
        mst_rdata_o <= mem.exists(a + 4 * i) ? mem[a + 4 * i] : ~mst_rdata_o;
        mst_last_o <= (i == n - 1);
        @(posedge clock_i);
        if (i == n - 1) begin
          mst_rvalid_o <= 1'b0;
          mst_last_o <= 1'b0;
          mst_rdata_o <= ~mst_rdata_o;
        end
      end
    end
  end
endmodule : hbu_mem

// ---- test/tb.sv ----
// self-checking testbench of the host bus unit
`timescale 1ns/1ps
`include "hbu_defs.svh"
module tb;
  logic clock_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, mst_addr_o, mst_rdata_i;
  logic [31:0] rx_addr_i = '0, q, ctrl;
  logic pready_o, pslverr_o, mst_oe_o, mst_req_o, mst_ack_i, mst_rvalid_i;
  logic mst_last_i, rx_done_o, int_o, int_oe_o, e, done;
  logic pci_rst_b_i = 1, rx_req_i = 0, rx_desc_i = 0, rx_event_i = 0;
  logic [3:0] mst_cmd_o;
  logic [7:0] mst_len_o, txq_free_i = 8'h20, rx_len_i = 8'h04;
  logic [7:0] rxq_level_i = '0;
  logic [15:0] rx_bytes_left_i = '0;
  int n_mismatch = 0, num_checks = 0, cyc = 0, words = 0, nf1, k;
  always #12.5 clock_i = ~clock_i;
  hbu_top #(.MAX_FRAGS(15)) DUT (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pci_rst_b_i(pci_rst_b_i),
    .mst_oe_o(mst_oe_o), .mst_req_o(mst_req_o), .mst_cmd_o(mst_cmd_o),
    .mst_addr_o(mst_addr_o), .mst_len_o(mst_len_o), .mst_ack_i(mst_ack_i),
    .mst_rvalid_i(mst_rvalid_i), .mst_rdata_i(mst_rdata_i),
    .mst_last_i(mst_last_i), .txq_free_i(txq_free_i), .rx_req_i(rx_req_i),
    .rx_desc_i(rx_desc_i), .rx_addr_i(rx_addr_i), .rx_len_i(rx_len_i),
    .rx_bytes_left_i(rx_bytes_left_i), .rxq_level_i(rxq_level_i),
    .rx_event_i(rx_event_i), .rx_done_o(rx_done_o), .int_o(int_o),
    .int_oe_o(int_oe_o));
  hbu_mem PART (.clock_i(clock_i), .pci_rst_b_i(pci_rst_b_i),
    .mst_req_i(mst_req_o), .mst_cmd_i(mst_cmd_o), .mst_addr_i(mst_addr_o),
    .mst_len_i(mst_len_o), .mst_ack_o(mst_ack_i),
    .mst_rvalid_o(mst_rvalid_i), .mst_rdata_o(mst_rdata_i),
    .mst_last_o(mst_last_i));
  // ==========================================================
  // reporting and comparison
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // hang guard, well above the longest list walk
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ==========================================================
  // apb master: entered and left just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    // only the bench timeout ends this wait
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    check(n, 1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    apb(1'b0, a, 32'h0000_0000);
    check(q, x);
    check(e, xe);
  endtask : rd
  // descriptor with nf fragments of 1 to 8 words in the model memory
  task automatic put_desc(input logic [31:0] b, input logic [31:0] l,
                          input logic nt, input int nf);
    logic [31:0] len;
    PART.mem[b] = l;
    PART.mem[b + 4] = {nt, 27'h0, 4'(nf)};
    for (int i = 0; i < nf; i++) begin
      len = 4 * $urandom_range(1, 8);
      PART.mem[b + 8 + 8 * i] = 32'h0001_0000 + (b << 4) + 32'h0000_0100 * i;
      PART.mem[b + 12 + 8 * i] = len;
      words += len / 4;
    end
  endtask : put_desc
  function automatic logic [3:0] rx_cmd(input logic d, input logic [15:0] bl,
                                        input logic [7:0] lv);
    if (!d && ctrl[17] && bl >= {ctrl[15:8], 2'b00} && lv >= ctrl[15:8])
      return `HBU_CMD_MWI;
    return `HBU_CMD_MW;
  endfunction : rx_cmd
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(7814));
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    rd(`HBU_OFS_HEAD, `HBU_HEAD_RST, 1'b0);
    rd(`HBU_OFS_CTRL, `HBU_CTRL_RST, 1'b0);
    rd(`HBU_OFS_STAT, 32'h0000_0000, 1'b0);
    rd(12'hFFC, 32'h0000_0000, 1'b1);
    check(mst_oe_o, 1'b1);
    ctrl = {14'h0, 2'b11, 8'h08, 8'($urandom_range(0, 8))};
    apb(1'b1, `HBU_OFS_CTRL, ctrl);
    rd(`HBU_OFS_CTRL, ctrl, 1'b0);
    apb(1'b1, `HBU_OFS_MASK, 32'h0000_0007);
    // two chained frames, the second with the full 15 fragments
    nf1 = $urandom_range(1, 3);
    put_desc(32'h0000_0100, 32'h0000_0200, 1'b1, nf1);
    put_desc(32'h0000_0200, 32'h0000_0000, 1'b0, 15);
    apb(1'b1, `HBU_OFS_HEAD, 32'h0000_0100);
    done = 1'b0;
    for (k = 0; k < 2000 && !done; k++) begin
      apb(1'b0, `HBU_OFS_STAT, 32'h0000_0000);
      done = q[`HBU_EV_LISTEND];
    end
    check(done, 1'b1);
    check(PART.n_desc, 2 + nf1 + 15);
    check(PART.n_bad, 0);
    check(PART.n_words, words);
    rd(`HBU_OFS_STAT, 32'h0000_0005, 1'b0);
    check(int_o, 1'b1);
    rd(`HBU_OFS_HEAD, 32'h0000_0000, 1'b0);
    rd(`HBU_OFS_TXST, 32'h000F_0000, 1'b0);
    apb(1'b1, `HBU_OFS_STAT, 32'h0000_0007);
    rd(`HBU_OFS_STAT, 32'h0000_0000, 1'b0);
    check(int_o, 1'b0);
    // masked receive event sets status but not the request line
    apb(1'b1, `HBU_OFS_MASK, 32'h0000_0000);
    rx_event_i <= 1'b1;
    @(posedge clock_i);
    rx_event_i <= 1'b0;
    @(posedge clock_i);
    rd(`HBU_OFS_STAT, 32'h0000_0002, 1'b0);
    check(int_o, 1'b0);
    apb(1'b1, `HBU_OFS_MASK, 32'h0000_0002);
    rd(`HBU_OFS_MASK, 32'h0000_0002, 1'b0);
    check(int_o, 1'b1);
    // receive bursts: descriptor write, invalidate, short queue
    for (k = 0; k < 3; k++) begin
      rx_req_i <= 1'b1;
      rx_desc_i <= (k == 0);
      rx_addr_i <= 32'h0002_0000;
      rx_bytes_left_i <= 16'h0100;
      rxq_level_i <= (k == 2) ? 8'h02 : 8'h40;
      done = 1'b0;
      for (int t = 0; t < 100 && !done; t++) begin
        @(posedge clock_i);
        done = (rx_done_o === 1'b1);
      end
      rx_req_i <= 1'b0;
      @(posedge clock_i);
      check(done, 1'b1);
      q = {28'h000_0000, rx_cmd(k == 0, 16'h0100, rxq_level_i)};
      check(PART.last_wcmd, q);
    end
    pci_rst_b_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    check(mst_oe_o, 1'b0);
    check(int_oe_o, 1'b0);
    pci_rst_b_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    check(mst_oe_o, 1'b1);
    check(int_oe_o, 1'b1);
    stop_test();
  end
endmodule : tb
